// File: tb/dac_capture.sv
/* far-side capture logic: latches both buses on the falling sample clock.
   assumes cap_clk changes just after hclk edges; released pins show a moving pattern. */
`timescale 1ns/1ps
module dac_capture (
  input wire logic hclk,
  input wire logic cap_clk,
  input wire logic [11:0] wa,
  input wire logic fa,
  input wire logic ea,
  input wire logic [11:0] wb,
  input wire logic fb,
  input wire logic eb,
  output logic [27:0] seen,
  output logic seen_v
);
  logic p_r = 1'b0;
  logic [12:0] la_r = 13'h0000;
  logic [12:0] lb_r = 13'h0000;
  // undriven pins toggle so a stale value never passes
  wire [12:0] pa = ea ? {fa, wa} : ~la_r;
  wire [12:0] pb = eb ? {fb, wb} : ~lb_r;
  always_ff @(posedge hclk) begin
    p_r <= cap_clk;
    la_r <= pa;
    lb_r <= pb;
    seen_v <= p_r & ~cap_clk;
    seen <= {ea, pa, eb, pb};
  end
endmodule

// File: tb/dac_top_sva.sv
/* checker on the dac_top ports: bus response, drive enables, stabilizer, quiet words, irq, swap.
   assumes one hclk domain; bound to every dac_top below. */
`timescale 1ns/1ps
module dac_top_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic channel_a_sample_clock,
  input wire logic channel_b_sample_clock,
  input wire logic [dac_pkg::word_w-1:0] bus_a_result_word,
  input wire logic [dac_pkg::word_w-1:0] bus_b_result_word,
  input wire logic bus_a_drive_en,
  input wire logic bus_b_drive_en,
  input wire logic stabilizer_on,
  input wire logic irq
);
  logic wc_r, wm_r, sa_r, sb_r;
  logic [6:0] ctl_r;
  logic [3:0] msk_r, cnt_r;
  logic [3:0] sq_r;
  wire take = hsel & hready & htrans[1] & hwrite;
  wire rise = channel_a_sample_clock & ~sa_r | channel_b_sample_clock & ~sb_r;
  // any transfer or sample edge restarts the quiet count
  wire evt = hsel & htrans[1] | rise;
  wire en_a = ~ctl_r[1] & ~ctl_r[3];
  wire en_b = ~ctl_r[2] & ~ctl_r[4];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wc_r <= 1'b0;
      wm_r <= 1'b0;
      sa_r <= 1'b0;
      sb_r <= 1'b0;
      cnt_r <= 4'h0;
      sq_r <= 4'h0;
      ctl_r <= 7'h01;
      msk_r <= 4'h0;
    end else begin
      wc_r <= take & (haddr[7:0] == dac_pkg::reg_control);
      wm_r <= take & (haddr[7:0] == dac_pkg::reg_irq_mask);
      sa_r <= channel_a_sample_clock;
      sb_r <= channel_b_sample_clock;
      cnt_r <= evt ? 4'h0 : cnt_r + 4'(cnt_r != 4'hf);
      // words settle a few cycles after a rise, so only quiet swaps are judged
      sq_r <= rise ? 4'h0 : sq_r + 4'(sq_r != 4'hf);
      if (wc_r) ctl_r <= hwdata[6:0];
      if (wm_r) msk_r <= hwdata[3:0];
    end
  end
  default clocking dck @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  a_stab_mode: assert property (stabilizer_on == (ctl_r[6:5] == 2'h2)) else $error("stabilizer");
  a_drive_bus_a: assert property (bus_a_drive_en == (ctl_r[0] ? en_a : en_b))
    else $error("bus a enable");
  a_drive_bus_b: assert property (bus_b_drive_en == (ctl_r[0] ? en_b : en_a))
    else $error("bus b enable");
  a_quiet_word_a: assert property (cnt_r > 4'h8 |-> $stable(bus_a_result_word))
    else $error("bus a moved");
  a_quiet_word_b: assert property (cnt_r > 4'h8 |-> $stable(bus_b_result_word))
    else $error("bus b moved");
  a_irq_masked: assert property (msk_r == 4'h0 |-> !irq) else $error("irq unmasked");
  a_swap_direct: assert property (sq_r > 4'h5 && $changed(ctl_r[0]) && $stable(ctl_r[6:5]) |->
    bus_a_result_word == $past(bus_b_result_word) && bus_b_result_word == $past(bus_a_result_word))
    else $error("swap not immediate");
endmodule
bind dac_top dac_top_sva chk_u (.*);

// File: tb/tb_dac_top.sv
/* bench for dac_top: ahb-lite tasks, sample clocking, expected-word queue.
   assumes dac_capture and the bound checker compile alongside. */
`timescale 1ns/1ps
module tb_dac_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic sclk = 1'b0;
  logic bon = 1'b1;
  logic channel_a_range = 1'b0;
  logic channel_b_range = 1'b0;
  logic [11:0] channel_a_code = 12'h000;
  logic [11:0] channel_b_code = 12'h000;
  wire hready, hreadyout, hresp, bus_a_range_flag, bus_b_range_flag, sv;
  wire bus_a_drive_en, bus_b_drive_en, stabilizer_on, irq;
  wire [31:0] hrdata;
  wire [11:0] bus_a_result_word, bus_b_result_word;
  wire [27:0] seen;
  wire channel_a_sample_clock = sclk;
  wire channel_b_sample_clock = sclk & bon;
  logic [6:0][12:0] ha = '0;
  logic [6:0][12:0] hb = '0;
  logic [6:0] ctl = 7'h01;
  wire en_a = ~ctl[1] & ~ctl[3];
  wire en_b = ~ctl[2] & ~ctl[4];
  logic [6:0] tbl [10] = '{7'h01, 7'h00, 7'h21, 7'h41, 7'h61, 7'h09, 7'h03, 7'h0b, 7'h01, 7'h15};
  logic [27:0] q [$];
  logic [27:0] e;
  logic [31:0] rs = 32'h0000_121a;
  int error_cnt = 0;
  int compares = 0;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  dac_top dut_u (.*);
  dac_capture cap_u (.hclk(hclk), .cap_clk(sclk), .wa(bus_a_result_word), .fa(bus_a_range_flag),
    .ea(bus_a_drive_en), .wb(bus_b_result_word), .fb(bus_b_range_flag), .eb(bus_b_drive_en),
    .seen(seen), .seen_v(sv));
  function logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // two's complement flips the msb only
  function logic [13:0] chv(input logic [12:0] h, input logic en);
    return {en, h[12], h[11] ^ ctl[6], h[10:0]};
  endfunction
  task summarize;
    $display("checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task wt;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 50) begin
      @(posedge hclk);
      i++;
    end
    if (i == 50) begin
      error_cnt++;
      summarize();
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
    @(posedge hclk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h00_0000, a};
    wt();
    {htrans, hwdata} <= {2'h0, d};
    wt();
    if (!w) cmp(hrdata, x);
  endtask
  task samp(input int n);
    for (int k = 0; k < n; k++) begin
      rs = nx(rs);
      @(posedge hclk);
      {channel_b_range, channel_a_range, channel_b_code, channel_a_code} <= rs[25:0];
      repeat (2) @(posedge hclk);
      sclk <= 1'b1;
      if (!ctl[1]) ha = {ha[5:0], rs[24], rs[11:0]};
      if (!ctl[2] && bon) hb = {hb[5:0], rs[25], rs[23:12]};
      q.push_back(ctl[0] ? {chv(ha[6], ~ctl[1] & ~ctl[3]), chv(hb[6], ~ctl[2] & ~ctl[4])}
        : {chv(hb[6], ~ctl[2] & ~ctl[4]), chv(ha[6], ~ctl[1] & ~ctl[3])});
      repeat (8) @(posedge hclk);
      sclk <= 1'b0;
      repeat (6) @(posedge hclk);
    end
  endtask
  // disabled buses are judged on their enable alone
  always @(posedge hclk) begin
    if (sv === 1'b1) begin
      e = (q.size() != 0) ? q.pop_front() : 'x;
      cmp(seen & {1'b1, {13{e[27]}}, 1'b1, {13{e[13]}}}, e & {1'b1, {13{e[27]}}, 1'b1, {13{e[13]}}});
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int p = 0; p < 10; p++) begin
      ctl = tbl[p];
      bon = (p != 8);
      bus(1'b1, 8'h00, {25'h000_0000, ctl}, 32'h0000_0000);
      bus(1'b0, 8'h00, 32'h0000_0000, {25'h000_0000, ctl});
      samp(8);
      bus(1'b0, 8'h10, 32'h0000_0000, {19'h0_0000, ha[6]});
      bus(1'b0, 8'h14, 32'h0000_0000, {19'h0_0000, hb[6]});
      bus(1'b0, 8'h04, 32'h0000_0000, {28'h000_0000, ctl[0] ? {en_b, en_a} : {en_a, en_b}, ~ctl[2], ~ctl[1]});
      $display("test %0d done", p);
    end
    bus(1'b1, 8'h08, 32'h0000_000f, 32'h0000_0000);
    bus(1'b1, 8'h0c, 32'h0000_0002, 32'h0000_0000);
    samp(1);
    @(posedge hclk);
    cmp(irq, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'h0000_000f, 32'h0000_0000);
    bus(1'b1, 8'h0c, 32'h0000_0001, 32'h0000_0000);
    bus(1'b0, 8'h0c, 32'h0000_0000, 32'h0000_0001);
    @(posedge hclk);
    cmp(irq, 32'h0000_0000);
    samp(1);
    @(posedge hclk);
    cmp(irq, 32'h0000_0001);
    bus(1'b1, 8'h08, 32'h0000_0001, 32'h0000_0000);
    @(posedge hclk);
    cmp(irq, 32'h0000_0000);
    bus(1'b0, 8'h40, 32'h0000_0000, 32'h0000_0000);
    $display("test irq done");
    summarize();
  end
endmodule

// File: verilog/dac_channel.sv
/*
  one converter channel: edge detect on its own sample clock, six-deep result pipeline.
  assumes the sample clock arrives asynchronously and is slow relative to hclk.
*/
`timescale 1ns/1ps
module dac_channel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sample_clock,
  input wire logic powered,
  input wire logic [dac_pkg::word_w-1:0] sample_code,
  input wire logic sample_range,
  output logic [dac_pkg::word_w-1:0] result_r,
  output logic range_r,
  output logic done
);
  logic [dac_pkg::sync_w-1:0] sync_r;
  logic level_r;
  logic [dac_pkg::word_w-1:0] pipe_code_r [dac_pkg::latency];
  logic pipe_range_r [dac_pkg::latency];
  logic edge_seen;

  // a rise counts once stages two and three agree; stage one may be metastable
  assign edge_seen = sync_r[1] & sync_r[2] & ~level_r;
  assign done = edge_seen & powered;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_r <= '0;
      level_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], sample_clock};
      if (sync_r[1] == sync_r[2]) begin
        level_r <= sync_r[2];
      end
    end
  end

  // one stage per sample edge; the code taken on an edge reaches result_r five edges later
  genvar i;
  generate
    for (i = 0; i < dac_pkg::latency; i++) begin : g_stage
      if (i == 0) begin : g_first
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            pipe_code_r[i] <= '0;
            pipe_range_r[i] <= 1'b0;
          end else if (done) begin
            pipe_code_r[i] <= sample_code;
            pipe_range_r[i] <= sample_range;
          end
        end
      end else begin : g_next
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            pipe_code_r[i] <= '0;
            pipe_range_r[i] <= 1'b0;
          end else if (done) begin
            pipe_code_r[i] <= pipe_code_r[i-1];
            pipe_range_r[i] <= pipe_range_r[i-1];
          end
        end
      end
    end
  endgenerate

  assign result_r = pipe_code_r[dac_pkg::latency-1];
  assign range_r = pipe_range_r[dac_pkg::latency-1];
endmodule

// File: verilog/dac_pkg.sv
/*
  shared constants for the dual converter output control block.
  assumes a single 125 MHz hclk domain and an ahb-lite register bus.
*/
package dac_pkg;
  localparam int unsigned word_w = 12;
  localparam int unsigned latency = 6;
  localparam int unsigned sync_w = 3;
  // register byte addresses
  localparam logic [7:0] reg_control = 8'h00;
  localparam logic [7:0] reg_status = 8'h04;
  localparam logic [7:0] reg_irq_stat = 8'h08;
  localparam logic [7:0] reg_irq_mask = 8'h0c;
  localparam logic [7:0] reg_sample_a = 8'h10;
  localparam logic [7:0] reg_sample_b = 8'h14;
  // control field positions
  localparam int unsigned ctl_swap = 0;
  localparam int unsigned ctl_pd_a = 1;
  localparam int unsigned ctl_pd_b = 2;
  localparam int unsigned ctl_oe_a = 3;
  localparam int unsigned ctl_oe_b = 4;
  localparam int unsigned ctl_mode = 5;
  localparam logic [31:0] ctl_reset = 32'h0000_0001;
  // interrupt bits
  localparam int unsigned irq_done_a = 0;
  localparam int unsigned irq_done_b = 1;
  localparam int unsigned irq_ovr_a = 2;
  localparam int unsigned irq_ovr_b = 3;
  localparam int unsigned irq_w = 4;
  typedef enum logic [1:0] {
    mode_gnd,
    mode_third,
    mode_two_thirds,
    mode_full
  } dac_mode_t;
  typedef enum logic [1:0] {
    pwr_normal,
    pwr_hiz,
    pwr_nap,
    pwr_sleep
  } dac_pwr_t;
endpackage

// File: verilog/dac_top.sv
/*
  dual converter output control: power modes, format, bus swap, ahb-lite registers, irq.
  assumes an analog front end presents codes and range flags; testbench resolves pin levels from enables.
*/
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - each channel samples on own clock rise
// - swap high: a to bus a, b to b
// - swap low: a to bus b, b to a
// - pd low, oe low: convert and drive
// - pd low, oe high: convert, outputs hi-z
// - pd high, oe low: nap, outputs hi-z
// - pd high, oe high: sleep, outputs hi-z
// - twelve-bit word, bit 11 is msb
// - range flag high on over or underflow
// - one mode input sets both channels
// - ground or third: binary, stabilizer off
// - two thirds: twos, on; full: twos, off
// - result appears six sample cycles later
module dac_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic channel_a_sample_clock,
  input wire logic channel_b_sample_clock,
  input wire logic [dac_pkg::word_w-1:0] channel_a_code,
  input wire logic [dac_pkg::word_w-1:0] channel_b_code,
  input wire logic channel_a_range,
  input wire logic channel_b_range,
  output logic [dac_pkg::word_w-1:0] bus_a_result_word,
  output logic bus_a_range_flag,
  output logic bus_a_drive_en,
  output logic [dac_pkg::word_w-1:0] bus_b_result_word,
  output logic bus_b_range_flag,
  output logic bus_b_drive_en,
  output logic stabilizer_on,
  output logic irq
);
  logic [31:0] ctl_r;
  logic [dac_pkg::irq_w-1:0] stat_r;
  logic [dac_pkg::irq_w-1:0] stat_nxt;
  logic [dac_pkg::irq_w-1:0] mask_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic [dac_pkg::word_w-1:0] res_a;
  logic [dac_pkg::word_w-1:0] res_b;
  logic rng_a;
  logic rng_b;
  logic done_a;
  logic done_b;
  logic [dac_pkg::word_w-1:0] fmt_a_r;
  logic [dac_pkg::word_w-1:0] fmt_b_r;
  logic fmt_rng_a_r;
  logic fmt_rng_b_r;
  logic [dac_pkg::word_w-1:0] hold_a_r;
  logic [dac_pkg::word_w-1:0] hold_b_r;
  logic hold_rng_a_r;
  logic hold_rng_b_r;

  function automatic dac_pkg::dac_pwr_t pwr_of(input logic pd, input logic oe_n);
    case ({pd, oe_n})
      2'b00: pwr_of = dac_pkg::pwr_normal;
      2'b01: pwr_of = dac_pkg::pwr_hiz;
      2'b10: pwr_of = dac_pkg::pwr_nap;
      default: pwr_of = dac_pkg::pwr_sleep;
    endcase
  endfunction

  wire swap = ctl_r[dac_pkg::ctl_swap];
  wire dac_pkg::dac_pwr_t pwr_a = pwr_of(ctl_r[dac_pkg::ctl_pd_a], ctl_r[dac_pkg::ctl_oe_a]);
  wire dac_pkg::dac_pwr_t pwr_b = pwr_of(ctl_r[dac_pkg::ctl_pd_b], ctl_r[dac_pkg::ctl_oe_b]);
  wire dac_pkg::dac_pwr_t pwr_bus_a = swap ? pwr_a : pwr_b;
  wire dac_pkg::dac_pwr_t pwr_bus_b = swap ? pwr_b : pwr_a;
  wire dac_pkg::dac_mode_t mode = dac_pkg::dac_mode_t'(ctl_r[dac_pkg::ctl_mode +: 2]);
  // one shared mode field, no per-channel copy exists
  wire twos = (mode == dac_pkg::mode_two_thirds) || (mode == dac_pkg::mode_full);
  wire run_a = (pwr_a == dac_pkg::pwr_normal) || (pwr_a == dac_pkg::pwr_hiz);
  wire run_b = (pwr_b == dac_pkg::pwr_normal) || (pwr_b == dac_pkg::pwr_hiz);

  assign stabilizer_on = (mode == dac_pkg::mode_two_thirds);

  dac_channel u_chan_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_clock(channel_a_sample_clock),
    .powered(run_a),
    .sample_code(channel_a_code),
    .sample_range(channel_a_range),
    .result_r(res_a),
    .range_r(rng_a),
    .done(done_a)
  );

  dac_channel u_chan_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_clock(channel_b_sample_clock),
    .powered(run_b),
    .sample_code(channel_b_code),
    .sample_range(channel_b_range),
    .result_r(res_b),
    .range_r(rng_b),
    .done(done_b)
  );

  // output word registered once per sample edge; format applied at the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmt_a_r <= '0;
      fmt_rng_a_r <= 1'b0;
    end else if (done_a) begin
      fmt_a_r <= res_a;
      fmt_rng_a_r <= rng_a;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmt_b_r <= '0;
      fmt_rng_b_r <= 1'b0;
    end else if (done_b) begin
      fmt_b_r <= res_b;
      fmt_rng_b_r <= rng_b;
    end
  end

  // msb flip gives twos complement, mid-scale becomes zero
  wire [dac_pkg::word_w-1:0] msb_flip = {1'b1, {(dac_pkg::word_w-1){1'b0}}};
  wire [dac_pkg::word_w-1:0] out_a = twos ? (fmt_a_r ^ msb_flip) : fmt_a_r;
  wire [dac_pkg::word_w-1:0] out_b = twos ? (fmt_b_r ^ msb_flip) : fmt_b_r;

  // pure mux, so a swap change reaches the pins in the same cycle
  assign bus_a_result_word = swap ? out_a : out_b;
  assign bus_a_range_flag = swap ? fmt_rng_a_r : fmt_rng_b_r;
  assign bus_b_result_word = swap ? out_b : out_a;
  assign bus_b_range_flag = swap ? fmt_rng_b_r : fmt_rng_a_r;
  assign bus_a_drive_en = (pwr_bus_a == dac_pkg::pwr_normal);
  assign bus_b_drive_en = (pwr_bus_b == dac_pkg::pwr_normal);

  // capture of latest words for software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_a_r <= '0;
      hold_b_r <= '0;
      hold_rng_a_r <= 1'b0;
      hold_rng_b_r <= 1'b0;
    end else begin
      if (done_a) begin
        hold_a_r <= res_a;
        hold_rng_a_r <= rng_a;
      end
      if (done_b) begin
        hold_b_r <= res_b;
        hold_rng_b_r <= rng_b;
      end
    end
  end

  // ahb-lite slave, zero wait states
  wire addr_ok = hsel & hready & htrans[1];
  wire wr_take = addr_ok & hwrite;
  wire rd_take = addr_ok & ~hwrite;
  wire wr_ctl = wr_pend_r && (wr_addr_r == dac_pkg::reg_control);
  wire wr_clr = wr_pend_r && (wr_addr_r == dac_pkg::reg_irq_stat);
  wire wr_msk = wr_pend_r && (wr_addr_r == dac_pkg::reg_irq_mask);
  wire [dac_pkg::irq_w-1:0] ev = {done_b & rng_b, done_a & rng_a, done_b, done_a};
  wire [dac_pkg::irq_w-1:0] clr = wr_clr ? hwdata[dac_pkg::irq_w-1:0] : '0;

  // set wins over clear in the same cycle
  assign stat_nxt = (stat_r & ~clr) | ev;
  assign irq = |(stat_r & mask_r);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  wire [31:0] status_word = {16'h0000, 12'h000, bus_b_drive_en, bus_a_drive_en, run_b, run_a};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux =
    (ra == dac_pkg::reg_control) ? ctl_r :
    (ra == dac_pkg::reg_status) ? status_word :
    (ra == dac_pkg::reg_irq_stat) ? {28'h000_0000, stat_r} :
    (ra == dac_pkg::reg_irq_mask) ? {28'h000_0000, mask_r} :
    (ra == dac_pkg::reg_sample_a) ? {19'h0_0000, hold_rng_a_r, hold_a_r} :
    (ra == dac_pkg::reg_sample_b) ? {19'h0_0000, hold_rng_b_r, hold_b_r} :
    32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rdata_r <= '0;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= haddr[7:0];
      if (rd_take) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r <= dac_pkg::ctl_reset;
      mask_r <= '0;
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_ctl) begin
        ctl_r <= {25'h000_0000, hwdata[6:0]};
      end
      if (wr_msk) begin
        mask_r <= hwdata[dac_pkg::irq_w-1:0];
      end
    end
  end
endmodule
